//--- rtl/group_scale.sv
/*
 Scales one position field by a power-of-two pixel group.
 Assumes the shift never exceeds 5, so the result fits 15 bits.
*/
`timescale 1ns/1ps
`default_nettype none
module group_scale (
   // Field and group size
   input wire logic [9:0] field_i,
   input wire logic [2:0] shift_i,
   // First and last pixel of the group
   output logic [15:0] first_o,
   output logic [15:0] last_o
);
   wire [15:0] ones_w = (16'h0001 << shift_i) - 16'h0001;

   assign first_o = {6'h00, field_i} << shift_i;
   // Low bits of first_o are zero, so an OR cannot carry
   assign last_o = first_o | ones_w;
endmodule
`default_nettype wire

//--- rtl/overlay_window_position.sv
/*
 Overlay window position registers, edge decoder for four rotations and
 pixel substitution select. Assumes the pixel coordinates arrive in the
 displayed orientation, synchronous to clk_i, and a master that never
 issues read and write strobes together.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "overlay_window_position_consts.svh"
module overlay_window_position (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Pixel position from the timing generator
   input wire logic pix_valid_i,
   input wire overlay_window_position_pkg::coord_t pix_col_i,
   input wire overlay_window_position_pkg::coord_t pix_line_i,
   // Decoded edges and select
   output overlay_window_position_pkg::coord_t left_o,
   output overlay_window_position_pkg::coord_t right_o,
   output overlay_window_position_pkg::coord_t top_o,
   output overlay_window_position_pkg::coord_t bottom_o,
   output logic overlay_sel_o
);
   import overlay_window_position_pkg::*;

   logic [31:0] hpos_r;
   logic [31:0] vpos_r;
   logic en_r;
   rotation_t rot_r;
   depth_t depth_r;
   panel_t pw_r;
   panel_t ph_r;
   coord_t left_r, right_r, top_r, bottom_r;
   coord_t left_nxt, right_nxt, top_nxt, bottom_nxt;
   logic sel_r;
   logic [31:0] rdata_r;
   logic [2:0] grp_shift;

   // Register decode
   wire wr_ctrl_w = wr_i && (addr_i == `OWP_ADDR_DISP_CTRL);
   wire wr_hpos_w = wr_i && (addr_i == `OWP_ADDR_HPOS);
   wire wr_vpos_w = wr_i && (addr_i == `OWP_ADDR_VPOS);
   wire wr_fmt_w = wr_i && (addr_i == `OWP_ADDR_FORMAT);
   wire wr_panel_w = wr_i && (addr_i == `OWP_ADDR_PANEL);

   // Position fields
   wire field_t xs_w = hpos_r[`OWP_FIRST_LSB +: 10];
   wire field_t xe_w = hpos_r[`OWP_LAST_LSB +: 10];
   wire field_t ys_w = vpos_r[`OWP_FIRST_LSB +: 10];
   wire field_t ye_w = vpos_r[`OWP_LAST_LSB +: 10];
   wire coord_t pw_w = {5'h00, pw_r};
   wire coord_t ph_w = {5'h00, ph_r};

   // Group of one 32-bit word; unknown depth codes fall back to 16 bpp
   always_comb begin
      case (depth_r)
         DEPTH_1: grp_shift = 3'h5;
         DEPTH_2: grp_shift = 3'h4;
         DEPTH_4: grp_shift = 3'h3;
         DEPTH_8: grp_shift = 3'h2;
         DEPTH_16: grp_shift = 3'h1;
         default: grp_shift = 3'h1;
      endcase
   end

   coord_t xs_f, xs_l, xe_f, xe_l, ys_f, ys_l, ye_f, ye_l;

   group_scale u_scale_xs (.field_i(xs_w), .shift_i(grp_shift), .first_o(xs_f), .last_o(xs_l));
   group_scale u_scale_xe (.field_i(xe_w), .shift_i(grp_shift), .first_o(xe_f), .last_o(xe_l));
   group_scale u_scale_ys (.field_i(ys_w), .shift_i(grp_shift), .first_o(ys_f), .last_o(ys_l));
   group_scale u_scale_ye (.field_i(ye_w), .shift_i(grp_shift), .first_o(ye_f), .last_o(ye_l));

   // Mirror about the panel extent; a position past the panel clamps to 0
   function automatic coord_t reflect(input coord_t extent, input coord_t v);
      logic [16:0] d;
      d = {1'b0, extent} - {1'b0, v} - 17'h00001;
      reflect = d[16] ? 16'h0000 : d[15:0];
   endfunction

   always_comb begin
      case (rot_r)
         ROT_0: begin
            left_nxt = xs_f;
            right_nxt = xe_l;
            top_nxt = {6'h00, ys_w};
            bottom_nxt = {6'h00, ye_w};
         end
         ROT_90: begin
            top_nxt = {6'h00, xs_w};
            bottom_nxt = {6'h00, xe_w};
            left_nxt = reflect(ph_w, ye_l);
            right_nxt = reflect(ph_w, ys_f);
         end
         ROT_180: begin
            left_nxt = reflect(pw_w, xe_l);
            right_nxt = reflect(pw_w, xs_f);
            top_nxt = reflect(ph_w, {6'h00, ye_w});
            bottom_nxt = reflect(ph_w, {6'h00, ys_w});
         end
         ROT_270: begin
            top_nxt = reflect(pw_w, {6'h00, xe_w});
            bottom_nxt = reflect(pw_w, {6'h00, xs_w});
            left_nxt = ys_f;
            right_nxt = ye_l;
         end
         default: begin
            left_nxt = xs_f;
            right_nxt = xe_l;
            top_nxt = {6'h00, ys_w};
            bottom_nxt = {6'h00, ye_w};
         end
      endcase
   end

   // Substitution test against the registered edges
   logic col_in, line_in;

   span_check u_span_col (.coord_i(pix_col_i), .lo_i(left_r), .hi_i(right_r),
      .inside_o(col_in));
   span_check u_span_line (.coord_i(pix_line_i), .lo_i(top_r), .hi_i(bottom_r),
      .inside_o(line_in));

   wire sel_nxt = en_r && pix_valid_i && col_in && line_in;

   // Read mux; reserved bits and unmapped addresses read zero
   wire [31:0] ctrl_rd_w = {12'h000, en_r, 19'h00000};
   wire [31:0] fmt_rd_w = {25'h0000000, depth_r, 2'b00, rot_r};
   wire [31:0] panel_rd_w = {5'h00, ph_r, 5'h00, pw_r};
   wire [31:0] rd_mux_w =
      (addr_i == `OWP_ADDR_DISP_CTRL) ? ctrl_rd_w :
      (addr_i == `OWP_ADDR_HPOS) ? hpos_r :
      (addr_i == `OWP_ADDR_VPOS) ? vpos_r :
      (addr_i == `OWP_ADDR_FORMAT) ? fmt_rd_w :
      (addr_i == `OWP_ADDR_PANEL) ? panel_rd_w :
      (addr_i == `OWP_ADDR_EDGE_H) ? {right_r, left_r} :
      (addr_i == `OWP_ADDR_EDGE_V) ? {bottom_r, top_r} : 32'h00000000;
   wire [31:0] rdata_nxt = rd_i ? rd_mux_w : 32'h00000000;

   // Software registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hpos_r <= `OWP_POS_RESET;
         vpos_r <= `OWP_POS_RESET;
         en_r <= `OWP_ENABLE_RESET;
         rot_r <= ROT_0;
         depth_r <= DEPTH_1;
         pw_r <= `OWP_PANEL_RESET;
         ph_r <= `OWP_PANEL_RESET;
      end else if (ce_i) begin
         if (wr_hpos_w) hpos_r <= wdata_i & `OWP_POS_MASK;
         if (wr_vpos_w) vpos_r <= wdata_i & `OWP_POS_MASK;
         if (wr_ctrl_w) en_r <= wdata_i[`OWP_ENABLE_BIT];
         if (wr_fmt_w) rot_r <= rotation_t'(wdata_i[`OWP_ROT_LSB +: 2]);
         if (wr_fmt_w) depth_r <= depth_t'(wdata_i[`OWP_BPP_LSB +: 3]);
         if (wr_panel_w) pw_r <= wdata_i[`OWP_PANEL_W_LSB +: 11];
         if (wr_panel_w) ph_r <= wdata_i[`OWP_PANEL_H_LSB +: 11];
      end
   end

   // Edges lag a register write by one cycle, far inside a line time
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         left_r <= 16'h0000;
         right_r <= 16'h0000;
         top_r <= 16'h0000;
         bottom_r <= 16'h0000;
         sel_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else if (ce_i) begin
         left_r <= left_nxt;
         right_r <= right_nxt;
         top_r <= top_nxt;
         bottom_r <= bottom_nxt;
         sel_r <= sel_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign left_o = left_r;
   assign right_o = right_r;
   assign top_o = top_r;
   assign bottom_o = bottom_r;
   assign overlay_sel_o = sel_r;
   assign rdata_o = rdata_r;

   vpos_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && wr_vpos_w |=> vpos_r == ($past(wdata_i) & 32'h03ff03ff))
      else $error("vertical position write not stored");

   hpos_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && wr_hpos_w ##1 ce_i && rd_i && addr_i == 8'h58
      |=> rdata_o == ($past(wdata_i, 2) & 32'h03ff03ff))
      else $error("horizontal position readback wrong");

   group_depth_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      depth_r == DEPTH_4 |-> (xs_l - xs_f) == 16'h0007)
      else $error("pixel group at 4 bpp is not 8");

   group_depth1_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      depth_r == DEPTH_1 |-> (xs_l - xs_f) == 16'h001f)
      else $error("pixel group at 1 bpp is not 32");

   group_depth16_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      depth_r == DEPTH_16 |-> (xs_l - xs_f) == 16'h0001)
      else $error("pixel group at 16 bpp is not 2");

   left_rot0_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_0 |=> left_r == ({6'h00, $past(xs_w)} << $past(grp_shift)))
      else $error("left edge at 0 degrees wrong");

   top_rot90_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_90 |=> top_r == {6'h00, $past(xs_w)})
      else $error("top edge at 90 degrees wrong");

   right_rot180_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_180 && pw_w > xs_f
      |=> right_r == ($past(pw_w) - 16'h0001 - $past(xs_f)))
      else $error("right edge at 180 degrees wrong");

   bottom_rot270_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_270 && pw_w > {6'h00, xs_w}
      |=> bottom_r == ($past(pw_w) - 16'h0001 - {6'h00, $past(xs_w)}))
      else $error("bottom edge at 270 degrees wrong");

   top_rot180_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_180 && ph_w > {6'h00, ye_w}
      |=> top_r == ($past(ph_w) - 16'h0001 - {6'h00, $past(ye_w)}))
      else $error("top edge at 180 degrees wrong");

   right_rot270_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_270
      |=> right_r == ((({6'h00, $past(ye_w)} + 16'h0001) << $past(grp_shift)) - 16'h0001))
      else $error("right edge at 270 degrees not a group end");

   enable_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && !en_r |=> !overlay_sel_o)
      else $error("overlay selected while disabled");

   inside_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i ##0 (en_r && pix_valid_i && pix_col_i >= left_r && pix_col_i <= right_r
      && pix_line_i >= top_r && pix_line_i <= bottom_r) |=> overlay_sel_o)
      else $error("overlay not selected inside window");

   outside_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && (pix_col_i > right_r || pix_col_i < left_r) |=> !overlay_sel_o)
      else $error("overlay selected outside window");

   top_rot0_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_0 |=> top_r == {6'h00, $past(ys_w)})
      else $error("top edge at 0 degrees wrong");

   bottom_rot0_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_0 |=> bottom_r == {6'h00, $past(ye_w)})
      else $error("bottom edge at 0 degrees wrong");

   left_rot90_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_90 && ph_w > ye_l
      |=> left_r == ($past(ph_w) - (({6'h00, $past(ye_w)} + 16'h0001) << $past(grp_shift))))
      else $error("left edge at 90 degrees wrong");

   right_rot90_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_90 && ph_w > ys_f
      |=> right_r == ($past(ph_w) - 16'h0001 - ({6'h00, $past(ys_w)} << $past(grp_shift))))
      else $error("right edge at 90 degrees wrong");

   bottom_rot180_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_180 && ph_w > {6'h00, ys_w}
      |=> bottom_r == ($past(ph_w) - 16'h0001 - {6'h00, $past(ys_w)}))
      else $error("bottom edge at 180 degrees wrong");

   left_rot270_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_270 |=> left_r == ({6'h00, $past(ys_w)} << $past(grp_shift)))
      else $error("left edge at 270 degrees wrong");

   // A start column past the panel has no mirror image, so the edge pins to 0
   right_clamp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && rot_r == ROT_180 && pw_w <= xs_f |=> right_r == 16'h0000)
      else $error("right edge at 180 degrees not clamped");
endmodule
`default_nettype wire

//--- rtl/overlay_window_position_consts.svh
/*
 Offsets, field positions and reset values of the overlay window position block.
 Assumes byte addresses on an 8-bit register port with 32-bit data.
*/
`ifndef OVERLAY_WINDOW_POSITION_CONSTS_SVH
`define OVERLAY_WINDOW_POSITION_CONSTS_SVH

`define OWP_ADDR_DISP_CTRL 8'h10
`define OWP_ADDR_HPOS 8'h58
`define OWP_ADDR_VPOS 8'h5c
`define OWP_ADDR_FORMAT 8'h60
`define OWP_ADDR_PANEL 8'h64
`define OWP_ADDR_EDGE_H 8'h68
`define OWP_ADDR_EDGE_V 8'h6c

`define OWP_POS_MASK 32'h03ff03ff
`define OWP_FIRST_LSB 0
`define OWP_LAST_LSB 16
`define OWP_ENABLE_BIT 19
`define OWP_ROT_LSB 0
`define OWP_BPP_LSB 4
`define OWP_PANEL_W_LSB 0
`define OWP_PANEL_H_LSB 16

`define OWP_POS_RESET 32'h00000000
`define OWP_ENABLE_RESET 1'b0
`define OWP_PANEL_RESET 11'h000

`endif

//--- rtl/overlay_window_position_pkg.sv
/*
 Types of the overlay window position block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package overlay_window_position_pkg;
   typedef enum logic [1:0] {
      ROT_0 = 2'b00,
      ROT_90 = 2'b01,
      ROT_180 = 2'b10,
      ROT_270 = 2'b11
   } rotation_t;

   typedef enum logic [2:0] {
      DEPTH_1 = 3'b000,
      DEPTH_2 = 3'b001,
      DEPTH_4 = 3'b010,
      DEPTH_8 = 3'b011,
      DEPTH_16 = 3'b100
   } depth_t;

   typedef logic [15:0] coord_t;
   typedef logic [9:0] field_t;
   typedef logic [10:0] panel_t;
endpackage

//--- rtl/span_check.sv
/*
 Inclusive range test of one coordinate.
 Assumes lo above hi means an empty span.
*/
`timescale 1ns/1ps
`default_nettype none
module span_check (
   // Coordinate and bounds
   input wire logic [15:0] coord_i,
   input wire logic [15:0] lo_i,
   input wire logic [15:0] hi_i,
   // Result
   output logic inside_o
);
   assign inside_o = (coord_i >= lo_i) && (coord_i <= hi_i);
endmodule
`default_nettype wire

//--- verification/testbench.sv
/*
 Self-checking bench for the overlay window position block: register port,
 edge decode over all rotations and depths, and the pixel select.
 Assumes the design files and the constants header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "overlay_window_position_consts.svh"
module testbench;
   import overlay_window_position_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic pix_valid_i = 1'b0;
   coord_t pix_col_i = 16'h0;
   coord_t pix_line_i = 16'h0;
   coord_t left_o, right_o, top_o, bottom_o;
   logic overlay_sel_o;
   logic chk = 1'b0;
   logic rd_d = 1'b0;
   logic sel_d = 1'b0;
   logic [7:0] rd_a = 8'h00;
   logic [31:0] exp_v = 32'h0;
   logic [31:0] exp_q[$];
   logic [31:0] lfsr = 32'hfd1e7588;
   logic [31:0] hp, vp, pn;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;

   overlay_window_position dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .pix_valid_i(pix_valid_i), .pix_col_i(pix_col_i), .pix_line_i(pix_line_i),
      .left_o(left_o), .right_o(right_o), .top_o(top_o), .bottom_o(bottom_o),
      .overlay_sel_o(overlay_sel_o));

   always #4 clk_i = ~clk_i;

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
      return lfsr;
   endfunction

   // Edges worked out independently; reflected values below zero clamp to zero
   function automatic logic [31:0] edges(input int rot, input int d, input logic [31:0] h_r,
         input logic [31:0] v_r, input logic [31:0] p_r, input bit vert);
      int g, xs, xe, ys, ye, w, h, l, r, t, b;
      // Depth codes past 16 bpp act as 16 bpp
      g = 32 >> ((d > 4) ? 4 : d);
      xs = h_r[9:0];
      xe = h_r[25:16];
      ys = v_r[9:0];
      ye = v_r[25:16];
      w = p_r[10:0];
      h = p_r[26:16];
      case (rot)
         0: begin
            l = xs * g;
            r = xe * g + g - 1;
            t = ys;
            b = ye;
         end
         1: begin
            t = xs;
            b = xe;
            l = h - 1 - (ye * g + g - 1);
            r = h - 1 - ys * g;
         end
         2: begin
            l = w - 1 - (xe * g + g - 1);
            r = w - 1 - xs * g;
            t = h - 1 - ye;
            b = h - 1 - ys;
         end
         default: begin
            t = w - 1 - xe;
            b = w - 1 - xs;
            l = ys * g;
            r = ye * g + g - 1;
         end
      endcase
      if (l < 0) l = 0;
      if (r < 0) r = 0;
      if (t < 0) t = 0;
      if (b < 0) b = 0;
      return vert ? {b[15:0], t[15:0]} : {r[15:0], l[15:0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      checks++;
      if (seen !== expd) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
      end
   endtask

   // Each task owns the strobes for one cycle, so back-to-back calls never double-assign
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      chk <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      chk <= 1'b0;
      exp_q.push_back(e);
   endtask

   task automatic pix(input logic v, input int c, input int l, input logic e);
      @(posedge clk_i);
      pix_valid_i <= v;
      pix_col_i <= c[15:0];
      pix_line_i <= l[15:0];
      chk <= 1'b1;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      exp_q.push_back({31'h0, e});
   endtask

   task automatic idle(input int n);
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      chk <= 1'b0;
      pix_valid_i <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask

   // Monitor: a result lands one cycle after its request and is judged mid-cycle
   always @(posedge clk_i) begin
      rd_d <= rd_i & ce_i & ~sys_rst_i;
      rd_a <= addr_i;
      sel_d <= chk & ce_i;
   end
   always @(negedge clk_i) begin
      if (rd_d | sel_d) begin
         if (exp_q.size() == 0) begin
            check(32'hdeadbeef, 32'h0);
         end else begin
            exp_v = exp_q.pop_front();
            check(rd_d ? rdata_o : {31'h0, overlay_sel_o}, exp_v);
            // The edge outputs must agree with the note of an edge register read
            if (rd_d && rd_a == `OWP_ADDR_EDGE_H) begin
               check({right_o, left_o}, exp_v);
            end
            if (rd_d && rd_a == `OWP_ADDR_EDGE_V) begin
               check({bottom_o, top_o}, exp_v);
            end
         end
      end
   end

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // Reset values; the edges follow the cleared fields one cycle after release
      rd(`OWP_ADDR_DISP_CTRL, 32'h0);
      rd(`OWP_ADDR_HPOS, `OWP_POS_RESET);
      rd(`OWP_ADDR_VPOS, `OWP_POS_RESET);
      rd(`OWP_ADDR_EDGE_H, edges(0, 0, `OWP_POS_RESET, `OWP_POS_RESET, 32'h0, 1'b0));
      rd(8'h70, 32'h0);
      idle(2);
      $display("test reset_values done");
      // Unused bits read zero; read-only and clock-disabled writes are dropped
      wr(`OWP_ADDR_HPOS, 32'hffffffff);
      rd(`OWP_ADDR_HPOS, `OWP_POS_MASK);
      wr(`OWP_ADDR_VPOS, 32'hffffffff);
      wr(`OWP_ADDR_DISP_CTRL, 32'hffffffff);
      wr(`OWP_ADDR_EDGE_H, 32'h12345678);
      rd(`OWP_ADDR_VPOS, `OWP_POS_MASK);
      rd(`OWP_ADDR_DISP_CTRL, 32'h00080000);
      rd(`OWP_ADDR_EDGE_H, edges(0, 0, 32'hffffffff, 32'hffffffff, 32'h0, 1'b0));
      idle(2);
      ce_i <= 1'b0;
      wr(`OWP_ADDR_VPOS, 32'h0);
      // The strobe must be gone before the enable returns, or the write lands late
      idle(0);
      ce_i <= 1'b1;
      rd(`OWP_ADDR_VPOS, `OWP_POS_MASK);
      idle(2);
      $display("test register_access done");
      // Every rotation and depth, code 5 past 16 bpp too, with random fields and panel
      for (int r = 0; r < 4; r++) begin
         for (int d = 0; d < 6; d++) begin
            hp = rnd();
            vp = rnd();
            pn = rnd() & 32'h07ff07ff;
            wr(`OWP_ADDR_HPOS, hp);
            wr(`OWP_ADDR_VPOS, vp);
            wr(`OWP_ADDR_PANEL, pn);
            wr(`OWP_ADDR_FORMAT, (d << 4) | r);
            idle(3);
            rd(`OWP_ADDR_EDGE_H, edges(r, d, hp, vp, pn, 1'b0));
            rd(`OWP_ADDR_EDGE_V, edges(r, d, hp, vp, pn, 1'b1));
            rd(`OWP_ADDR_VPOS, vp & `OWP_POS_MASK);
            rd(`OWP_ADDR_FORMAT, (d << 4) | r);
            rd(`OWP_ADDR_PANEL, pn);
         end
      end
      idle(2);
      $display("test rotation_decode done");
      // Landscape window at 80,60 size 160x120, 4 bpp, on a 320x240 panel
      wr(`OWP_ADDR_FORMAT, 32'h00000020);
      wr(`OWP_ADDR_PANEL, 32'h00f00140);
      wr(`OWP_ADDR_HPOS, 32'h001d000a);
      wr(`OWP_ADDR_VPOS, 32'h00b3003c);
      wr(`OWP_ADDR_DISP_CTRL, 32'h0);
      idle(3);
      rd(`OWP_ADDR_EDGE_H, {16'd239, 16'd80});
      pix(1'b1, 80, 60, 1'b0);
      wr(`OWP_ADDR_DISP_CTRL, 32'h00080000);
      idle(3);
      pix(1'b1, 80, 60, 1'b1);
      pix(1'b1, 79, 60, 1'b0);
      pix(1'b1, 239, 179, 1'b1);
      pix(1'b1, 240, 179, 1'b0);
      pix(1'b1, 80, 180, 1'b0);
      pix(1'b1, 80, 59, 1'b0);
      pix(1'b0, 100, 100, 1'b0);
      idle(2);
      $display("test pixel_select done");
      // Reset in mid-run clears the programmed position
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(`OWP_ADDR_VPOS, `OWP_POS_RESET);
      rd(`OWP_ADDR_DISP_CTRL, 32'h0);
      idle(3);
      $display("test mid_reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
